// ---- rtl/tefr_event_flag.sv ----
// Sticky event flag with set priority over clear
`timescale 1ns/10ps
`default_nettype none

module tefr_event_flag (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic set, // Event strobe
    input wire logic clr, // Clear request
    output logic flag_q // Sticky flag
);

    // Set wins so an event landing on a clear is never lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1; // [R14]
        end else if (clr) begin
            flag_q <= 1'b0; // [R4]
        end
    end

endmodule
`default_nettype wire

// ---- rtl/tefr_pkg.sv ----
// Constants for the timer event flag and request logic
package tefr_pkg;

    // Register field width and bus address width
    localparam int REG_W = 8;
    localparam int ADDR_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_MODE = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_XMODE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 4'h4;

    // Event register fields
    localparam int FLAG_CAP_BIT = 0;
    localparam int FLAG_REF_BIT = 1;

    // Mode register fields
    localparam int MODE_REF_REQUEST_ENABLE_BIT = 4;
    localparam int MODE_CE_LSB = 6;
    localparam int MODE_CE_MSB = 7;

    // Extended mode register fields
    localparam int XMODE_DMA_BIT = 7;

    // Reset values
    localparam logic [REG_W-1:0] RST_REG = 8'h00;
    localparam logic [1:0] RST_CE = 2'h0;

    // Capture edge selection
    typedef enum logic [1:0] {
        CE_NONE,
        CE_RISE,
        CE_FALL,
        CE_ANY
    } tefr_ce_type;

endpackage

// ---- rtl/tefr_req_route.sv ----
// Gates one flag by its enable and routes it to interrupt or DMA
`timescale 1ns/10ps
`default_nettype none

module tefr_req_route (
    input wire logic flag, // Event flag
    input wire logic enable, // Request enable for this flag
    input wire logic dma_sel, // High routes to DMA, low to interrupt
    output logic irq_cond, // Interrupt condition
    output logic dma_cond // DMA condition
);

    // Enable gates only the request; the flag itself is untouched here
    assign irq_cond = flag && enable && !dma_sel; // [R9] [R12]
    assign dma_cond = flag && enable && dma_sel; // [R9] [R12]

endmodule
`default_nettype wire

// ---- rtl/tefr_top.sv ----
// Event flags, mode bits and request outputs of one timer channel
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [R1] Count equals reference sets reference flag
// [R2] Capture event sets the capture flag
// [R3] Flags set regardless of any enable
// [R4] Writing one clears a flag, zero keeps
// [R5] One write may clear both flags
// [R6] Interrupt level holds until flag cleared
// [R7] Handler should clear flags early
// [R8] DMA acknowledge clears both flags
// [R9] Reference request gated by enable, routed
// [R10] Edge field: none, rise, fall, any
// [R11] Nonzero edge field requests on capture flag
// [R12] DMA select routes both requests
// [R13] Outputs OR conditions; reserved bits zero
// [R14] Set wins over a coinciding clear
module tefr_top #(
    parameter int ADDR_W = tefr_pkg::ADDR_W, // Register address width
    parameter int DATA_W = tefr_pkg::REG_W // Register data width
) (
    input wire logic CLK_SYS, // System clock, 20 MHz
    input wire logic RSTN, // Asynchronous reset, active low
    input wire logic [ADDR_W-1:0] REG_ADDR, // Register address
    input wire logic [DATA_W-1:0] REG_WDATA, // Write data
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    output logic [DATA_W-1:0] REG_RDATA, // Read data, cycle after strobe
    input wire logic MATCH_EVT, // Count reached reference, pulse
    input wire logic CAPTURE_EVT, // Capture edge seen, pulse
    input wire logic DMA_ACK, // DMA transfer acknowledge, pulse
    output logic [1:0] CAPTURE_EDGE_SEL, // Edge selection to capture logic
    output logic IRQ_REQ, // Interrupt request level
    output logic DMA_REQ // DMA request level
);

    // Refuse shapes the decode cannot serve
    if (DATA_W < tefr_pkg::REG_W) begin : g_chk_data
        $error("DATA_W must be at least eight bits");
    end
    if (ADDR_W < tefr_pkg::ADDR_W) begin : g_chk_addr
        $error("ADDR_W too narrow for the register map");
    end

    logic rst_meta_q;
    logic rst_n_q;
    logic rst_n;
    logic ref_flag;
    logic cap_flag;
    logic ref_en_q;
    logic [1:0] ce_q;
    logic dma_sel_q;
    logic cap_en;
    logic ref_irq;
    logic ref_dma;
    logic cap_irq;
    logic cap_dma;
    logic wr_flags;
    logic wr_clear;
    logic clr_ref;
    logic clr_cap;
    logic irq_q;
    logic irq_d;
    logic dma_q;
    logic dma_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [tefr_pkg::REG_W-1:0] flags_view;
    logic [tefr_pkg::REG_W-1:0] mode_view;
    logic [tefr_pkg::REG_W-1:0] xmode_view;
    tefr_pkg::tefr_ce_type ce_mode;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_n_q;

    // Write decode
    assign wr_flags = REG_WR && (REG_ADDR == tefr_pkg::OFS_FLAGS);
    assign wr_clear = REG_WR && (REG_ADDR == tefr_pkg::OFS_INT_CLEAR);

    // Clears from software ones or from the DMA acknowledge
    assign clr_ref = ((wr_flags || wr_clear) && REG_WDATA[tefr_pkg::FLAG_REF_BIT]) // [R4] [R5]
        || DMA_ACK; // [R8]
    assign clr_cap = ((wr_flags || wr_clear) && REG_WDATA[tefr_pkg::FLAG_CAP_BIT]) // [R4] [R5]
        || DMA_ACK; // [R8]

    // Reference flag, set by match with no enable in the path
    tefr_event_flag u_ref_flag (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .set(MATCH_EVT), // [R1] [R3]
        .clr(clr_ref),
        .flag_q(ref_flag)
    );

    // Capture flag, set by capture with no enable in the path
    tefr_event_flag u_cap_flag (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .set(CAPTURE_EVT), // [R2] [R3]
        .clr(clr_cap),
        .flag_q(cap_flag)
    );

    // Mode bits: edge selection and reference request enable
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ce_q <= tefr_pkg::RST_CE;
            ref_en_q <= 1'b0;
        end else if (REG_WR && (REG_ADDR == tefr_pkg::OFS_MODE)) begin
            ce_q <= REG_WDATA[tefr_pkg::MODE_CE_MSB:tefr_pkg::MODE_CE_LSB];
            ref_en_q <= REG_WDATA[tefr_pkg::MODE_REF_REQUEST_ENABLE_BIT];
        end
    end

    // DMA select, one bit shared by both request sources
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            dma_sel_q <= 1'b0;
        end else if (REG_WR && (REG_ADDR == tefr_pkg::OFS_XMODE)) begin
            dma_sel_q <= REG_WDATA[tefr_pkg::XMODE_DMA_BIT];
        end
    end

    // Any edge choice other than none enables the capture request
    assign ce_mode = tefr_pkg::tefr_ce_type'(ce_q);
    always_comb begin
        unique case (ce_mode)
            tefr_pkg::CE_NONE: cap_en = 1'b0; // [R10]
            tefr_pkg::CE_RISE: cap_en = 1'b1; // [R10]
            tefr_pkg::CE_FALL: cap_en = 1'b1; // [R10]
            tefr_pkg::CE_ANY: cap_en = 1'b1; // [R10]
        endcase
    end

    // Request routing for the reference flag
    tefr_req_route u_ref_route (
        .flag(ref_flag),
        .enable(ref_en_q),
        .dma_sel(dma_sel_q),
        .irq_cond(ref_irq),
        .dma_cond(ref_dma)
    );

    // Request routing for the capture flag
    tefr_req_route u_cap_route (
        .flag(cap_flag),
        .enable(cap_en), // [R11]
        .dma_sel(dma_sel_q),
        .irq_cond(cap_irq),
        .dma_cond(cap_dma)
    );

    // Outputs are ORs of the routed conditions
    assign irq_d = ref_irq || cap_irq; // [R13]
    assign dma_d = ref_dma || cap_dma; // [R13]

    // Registered requests; one cycle late but glitch free at the pins
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            dma_q <= 1'b0;
        end else begin
            irq_q <= irq_d; // [R6]
            dma_q <= dma_d;
        end
    end

    // Register views, unused bits held at zero
    always_comb begin
        flags_view = tefr_pkg::RST_REG;
        flags_view[tefr_pkg::FLAG_REF_BIT] = ref_flag;
        flags_view[tefr_pkg::FLAG_CAP_BIT] = cap_flag;
        mode_view = tefr_pkg::RST_REG;
        mode_view[tefr_pkg::MODE_CE_MSB:tefr_pkg::MODE_CE_LSB] = ce_q;
        mode_view[tefr_pkg::MODE_REF_REQUEST_ENABLE_BIT] = ref_en_q;
        xmode_view = tefr_pkg::RST_REG;
        xmode_view[tefr_pkg::XMODE_DMA_BIT] = dma_sel_q;
    end

    // Read mux; clear register and unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        if (REG_RD) begin
            unique case (REG_ADDR)
                tefr_pkg::OFS_FLAGS: rdata_d[tefr_pkg::REG_W-1:0] = flags_view; // [R13]
                tefr_pkg::OFS_INT_STATUS: rdata_d[tefr_pkg::REG_W-1:0] = flags_view;
                tefr_pkg::OFS_MODE: rdata_d[tefr_pkg::REG_W-1:0] = mode_view;
                tefr_pkg::OFS_XMODE: rdata_d[tefr_pkg::REG_W-1:0] = xmode_view;
                default: rdata_d = '0;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign IRQ_REQ = irq_q;
    assign DMA_REQ = dma_q;
    assign CAPTURE_EDGE_SEL = ce_q;

    // Checks on the design's own behaviour
    default clocking cb_sys @(posedge CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    AST_REF_SET: assert property (MATCH_EVT |=> ref_flag) // [R1]
        else $error("reference flag not set after match");

    AST_CAP_SET: assert property (CAPTURE_EVT |=> cap_flag) // [R2]
        else $error("capture flag not set after capture");

    AST_SET_NO_ENABLE: assert property ((MATCH_EVT && !ref_en_q && CAPTURE_EVT && !cap_en)
        |=> (ref_flag && cap_flag)) // [R3]
        else $error("flag set depended on an enable");

    AST_W1C_REF: assert property ((wr_flags && REG_WDATA[tefr_pkg::FLAG_REF_BIT] && !MATCH_EVT)
        |=> !ref_flag) // [R4]
        else $error("write one did not clear reference flag");

    AST_W0_KEEPS: assert property ((ref_flag && REG_WR && !REG_WDATA[tefr_pkg::FLAG_REF_BIT] && !DMA_ACK)
        |=> ref_flag) // [R4]
        else $error("write zero disturbed reference flag");

    AST_CLEAR_BOTH: assert property ((wr_flags && REG_WDATA[tefr_pkg::FLAG_REF_BIT]
        && REG_WDATA[tefr_pkg::FLAG_CAP_BIT] && !MATCH_EVT && !CAPTURE_EVT)
        |=> (!ref_flag && !cap_flag)) // [R5]
        else $error("single write did not clear both flags");

    // One cycle only: a later write may lawfully drop the enable or the flag
    AST_IRQ_HOLDS: assert property ((ref_flag && ref_en_q && !dma_sel_q && !clr_ref)
        |=> (ref_flag && IRQ_REQ)) // [R6]
        else $error("interrupt dropped while flag still set");

    AST_IRQ_DROPS: assert property ((!ref_irq && !cap_irq) |=> !IRQ_REQ) // [R6]
        else $error("interrupt high with no enabled flag");

    AST_DMA_DROPS: assert property ((!ref_dma && !cap_dma) |=> !DMA_REQ) // [R13]
        else $error("DMA request high with no enabled flag");

    AST_CAP_STICKY: assert property ((cap_flag && !clr_cap) |=> cap_flag) // [R3]
        else $error("capture flag fell without a clear");

    AST_ACK_CLEARS: assert property ((DMA_ACK && !MATCH_EVT && !CAPTURE_EVT)
        |=> (!ref_flag && !cap_flag)) // [R8]
        else $error("DMA acknowledge did not clear flags");

    AST_REF_ROUTE: assert property ((ref_flag && ref_en_q)
        |=> (IRQ_REQ == !$past(dma_sel_q)) && (DMA_REQ == $past(dma_sel_q))) // [R9] [R12]
        else $error("reference request misrouted");

    AST_REF_GATED: assert property ((ref_flag && !ref_en_q && !cap_flag)
        |=> (!IRQ_REQ && !DMA_REQ)) // [R9]
        else $error("reference request without enable");

    AST_CAP_NONE: assert property ((cap_flag && ce_q == 2'h0 && !ref_flag)
        |=> (!IRQ_REQ && !DMA_REQ)) // [R10] [R11]
        else $error("capture request with edge field none");

    AST_CAP_ROUTE: assert property ((cap_flag && ce_q != 2'h0)
        |=> (IRQ_REQ || DMA_REQ) && (DMA_REQ == $past(dma_sel_q))) // [R11] [R12]
        else $error("capture request missing or misrouted");

    AST_RSVD_ZERO: assert property (REG_RD |=> (REG_RDATA[tefr_pkg::REG_W-1:tefr_pkg::FLAG_REF_BIT+1] == '0
        || $past(REG_ADDR) == tefr_pkg::OFS_MODE || $past(REG_ADDR) == tefr_pkg::OFS_XMODE)) // [R13]
        else $error("reserved event bits read nonzero");

    AST_NO_BOTH_OUT: assert property (!(IRQ_REQ && DMA_REQ)) // [R12]
        else $error("interrupt and DMA request together");

    AST_SET_WINS: assert property ((MATCH_EVT && clr_ref) |=> ref_flag) // [R14]
        else $error("clear beat a coinciding event");

    AST_RD_ONE_CYCLE: assert property (!$past(REG_RD) |-> (REG_RDATA == '0)) // [R13]
        else $error("read data outside its cycle");

    // Main scenarios
    COV_REF_IRQ: cover property (MATCH_EVT ##1 ref_flag && ref_en_q && !dma_sel_q ##1 IRQ_REQ);
    COV_CAP_DMA: cover property (CAPTURE_EVT ##1 cap_en && dma_sel_q ##1 DMA_REQ ##[1:8] DMA_ACK);
    COV_SET_CLEAR: cover property (MATCH_EVT && wr_flags && REG_WDATA[tefr_pkg::FLAG_REF_BIT]);
    COV_BOTH_CLEARED: cover property (ref_flag && cap_flag ##1 wr_flags ##1 !ref_flag && !cap_flag);

endmodule
`default_nettype wire

// ---- tb/tb_tefr_top.sv ----
// Self-checking bench for the timer event flag and request logic
`timescale 1ns/10ps
`default_nettype none

module tb_tefr_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic match_evt = 1'b0;
    logic capture_evt = 1'b0;
    logic ack_en = 1'b0;
    logic dma_ack;
    logic [7:0] reg_rdata;
    logic [1:0] edge_sel;
    logic irq_req;
    logic dma_req;
    int errors = 0;
    int n_tests = 0;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    tefr_top uut (.CLK_SYS(clk_sys), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MATCH_EVT(match_evt),
        .CAPTURE_EVT(capture_evt), .DMA_ACK(dma_ack), .CAPTURE_EDGE_SEL(edge_sel),
        .IRQ_REQ(irq_req), .DMA_REQ(dma_req));

    tefr_dma_partner #(.ACK_DLY(3)) partner (.clk(clk_sys), .rst_n(rstn), .dma_req(dma_req),
        .ack_en(ack_en), .dma_ack(dma_ack));

    task wrap_up;
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Extra idle edge keeps back-to-back calls from assigning a strobe twice
    task wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read data are looked at only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge clk_sys);
    endtask

    // Event pulses; requests have settled when this returns
    task ev(input logic m, input logic c);
        match_evt <= m;
        capture_evt <= c;
        @(posedge clk_sys);
        match_evt <= 1'b0;
        capture_evt <= 1'b0;
        @(posedge clk_sys);
    endtask

    task outs(input logic i, input logic d);
        #1;
        chk({6'h00, irq_req, dma_req}, {6'h00, i, d});
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        outs(1'b0, 1'b0);
        rd(tefr_pkg::OFS_FLAGS, 8'h00);
        rd(tefr_pkg::OFS_MODE, 8'h00);
        rd(tefr_pkg::OFS_XMODE, 8'h00);
        rd(4'hF, 8'h00);
        // Flags set with every enable off, no request follows
        ev(1'b1, 1'b0);
        outs(1'b0, 1'b0);
        rd(tefr_pkg::OFS_FLAGS, 8'h02);
        ev(1'b0, 1'b1);
        rd(tefr_pkg::OFS_FLAGS, 8'h03);
        rd(tefr_pkg::OFS_INT_STATUS, 8'h03);
        wr(tefr_pkg::OFS_FLAGS, 8'hFC);
        rd(tefr_pkg::OFS_FLAGS, 8'h03);
        wr(tefr_pkg::OFS_FLAGS, 8'h02);
        rd(tefr_pkg::OFS_FLAGS, 8'h01);
        wr(tefr_pkg::OFS_INT_CLEAR, 8'h01);
        rd(tefr_pkg::OFS_FLAGS, 8'h00);
        ev(1'b1, 1'b1);
        wr(tefr_pkg::OFS_FLAGS, 8'h03);
        rd(tefr_pkg::OFS_FLAGS, 8'h00);
        // Reserved mode bits read back as zero
        wr(tefr_pkg::OFS_MODE, 8'hFF);
        rd(tefr_pkg::OFS_MODE, 8'hD0);
        wr(tefr_pkg::OFS_XMODE, 8'hFF);
        rd(tefr_pkg::OFS_XMODE, 8'h80);
        wr(tefr_pkg::OFS_XMODE, 8'h00);
        // Reference interrupt holds until its own flag or its enable goes
        wr(tefr_pkg::OFS_MODE, 8'h10);
        ev(1'b1, 1'b1);
        outs(1'b1, 1'b0);
        wr(tefr_pkg::OFS_FLAGS, 8'h01);
        outs(1'b1, 1'b0);
        wr(tefr_pkg::OFS_MODE, 8'h00);
        outs(1'b0, 1'b0);
        wr(tefr_pkg::OFS_MODE, 8'h10);
        outs(1'b1, 1'b0);
        wr(tefr_pkg::OFS_FLAGS, 8'h02);
        outs(1'b0, 1'b0);
        // Each edge setting against a capture flag
        for (int ce = 0; ce < 4; ce++) begin
            wr(tefr_pkg::OFS_MODE, 8'(ce << 6));
            chk({6'h00, edge_sel}, 8'(ce));
            ev(1'b0, 1'b1);
            outs(ce != 0, 1'b0);
            wr(tefr_pkg::OFS_FLAGS, 8'h01);
            outs(1'b0, 1'b0);
        end
        // Set wins over a clear in the same cycle
        match_evt <= 1'b1;
        reg_addr <= tefr_pkg::OFS_FLAGS;
        reg_wdata <= 8'h02;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        match_evt <= 1'b0;
        reg_wr <= 1'b0;
        @(posedge clk_sys);
        rd(tefr_pkg::OFS_FLAGS, 8'h02);
        // DMA routing and acknowledge clearing both flags
        wr(tefr_pkg::OFS_MODE, 8'h50);
        wr(tefr_pkg::OFS_XMODE, 8'h80);
        ev(1'b0, 1'b1);
        outs(1'b0, 1'b1);
        rd(tefr_pkg::OFS_FLAGS, 8'h03);
        ack_en <= 1'b1;
        for (int i = 0; i <= 20 && dma_req !== 1'b0; i++) begin
            if (i == 20) begin
                chk({7'h00, dma_req}, 8'h00);
                wrap_up();
            end
            @(posedge clk_sys);
        end
        ack_en <= 1'b0;
        rd(tefr_pkg::OFS_FLAGS, 8'h00);
        outs(1'b0, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire

// ---- tb/tefr_dma_partner.sv ----
// Behavioural DMA controller that acknowledges the timer's requests
`timescale 1ns/10ps
`default_nettype none

module tefr_dma_partner #(
    parameter int ACK_DLY = 3 // Cycles of request before the acknowledge
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic dma_req, // Request level from the timer
    input wire logic ack_en, // Bench lets transfers run
    output logic dma_ack // One-cycle acknowledge
);
    int wait_q;
    logic done_q;

    // One acknowledge per request; waits for the level to drop before rearming
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 0;
            done_q <= 1'b0;
            dma_ack <= 1'b0;
        end else begin
            dma_ack <= 1'b0;
            if (!dma_req) begin
                wait_q <= 0;
                done_q <= 1'b0;
            end else if (ack_en && !done_q) begin
                if (wait_q >= ACK_DLY) begin
                    dma_ack <= 1'b1;
                    done_q <= 1'b1;
                end else begin
                    wait_q <= wait_q + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire
